// ===== dv/ccgen_clock_gen_bench.sv
// self-checking bench for the clock generation block
`timescale 1ns/1ps
`default_nettype none
module ccgen_clock_gen_bench;
  import ccgen_pkg::*;
  localparam int LOCK_CYC = 20;
  logic            core_clk, nrst, irc_pin, sys_pin, wdo_pin;
  logic            irc_en, pll_pd, ref_sys, wdt_sel;
  logic            main_clk, wdt_clk, clkout, pll_clk;
  logic [3:0]      wdo_code, code_o;
  ccgen_pll_cfg_t  cfg;
  ccgen_main_sel_t main_sel;
  ccgen_out_sel_t  out_sel;
  ccgen_status_t   status;
  int              err_count, n_checks, cyc;

  ccgen_clock_gen #(.LOCK_CYCLES(LOCK_CYC)) uut (
    .core_clk(core_clk), .nrst(nrst), .irc_clk_pin(irc_pin),
    .sys_osc_clk_pin(sys_pin), .watchdog_oscillator_clk_pin(wdo_pin),
    .irc_en(irc_en), .wdo_freq_code(wdo_code), .pll_pd(pll_pd),
    .pll_ref_sysosc(ref_sys), .pll_cfg(cfg), .main_sel(main_sel),
    .wdt_sel_wdo(wdt_sel), .clkout_sel(out_sel), .main_clk(main_clk),
    .wdt_clk(wdt_clk), .clkout(clkout), .pll_clk(pll_clk),
    .wdo_freq_code_o(code_o), .status(status));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // sources: rc 16, system 8, watchdog 40 core cycles a period
  // ----------------------------------------------------------------
  always @(negedge core_clk)
  begin
    cyc = cyc + 1;
    irc_pin = (cyc % 16) < 8;
    sys_pin = (cyc % 8) < 4;
    wdo_pin = (cyc % 40) < 20;
    if (cyc > 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(string what, logic [3:0] exp, logic [3:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s exp %0h got %0h", what, exp, got);
    end
  endtask
  // rising edges in 160 cycles after settling; one edge of slack
  task automatic count(string what, int sel, int exp);
    int   n;
    logic prev;
    logic now;
    n = 0;
    prev = 1'b1;
    repeat (60) @(negedge core_clk);
    repeat (160)
    begin
      @(negedge core_clk);
      now = sel == 0 ? main_clk : sel == 1 ? wdt_clk
          : sel == 2 ? clkout : pll_clk;
      if (now === 1'b1 && prev === 1'b0)
        n++;
      prev = now;
    end
    n_checks++;
    if (n < exp - 1 || n > exp + 1)
    begin
      err_count++;
      $display("wrong value %s exp %0d got %0d", what, exp, n);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_mux();
    int exp[4] = '{10, 20, 4, 10};
    count("main rc", 0, 10);
    count("wdt rc", 1, 10);
    count("pll bypass", 3, 10);
    check("bypassed", 4'h1, 4'(status.pll_bypassed));
    for (int i = 0; i < 4; i++)
    begin
      out_sel = ccgen_out_sel_t'(i);
      count("clkout", 2, exp[i]);
    end
    wdt_sel = 1'b1;
    count("wdt wdo", 1, 4);
    wdo_code = 4'ha;
    repeat (2) @(negedge core_clk);
    check("wdo code", 4'ha, code_o);
    main_sel = CCGEN_MAIN_WDO;
    count("main wdo", 0, 4);
    main_sel = CCGEN_MAIN_PLL_IN;
    ref_sys = 1'b1;
    count("main ref sys", 0, 20);
    ref_sys = 1'b0;
    count("main ref rc", 0, 10);
    main_sel = CCGEN_MAIN_IRC;
    wdt_sel = 1'b0;
    out_sel = CCGEN_OUT_IRC;
    $display("test muxes done");
  endtask

  task automatic t_gate();
    irc_en = 1'b0;
    count("main gated", 0, 0);
    count("clkout gated", 2, 0);
    irc_en = 1'b1;
    count("main ungated", 0, 10);
    $display("test gate done");
  endtask

  task automatic t_pll();
    int exp[4] = '{70, 35, 18, 9};
    cfg = '{msel: 5'h00, psel: 2'h0};
    pll_pd = 1'b0;
    repeat (LOCK_CYC - 3) @(negedge core_clk);
    check("lock early", 4'h0, 4'(status.pll_lock));
    repeat (6) @(negedge core_clk);
    check("lock", 4'h1, 4'(status.pll_lock));
    check("running", 4'h0, 4'(status.pll_bypassed));
    repeat (40) @(negedge core_clk);
    check("range x1", 4'h0, 4'(status.cco_in_range));
    // multiplier 14 on a 16-cycle reference
    for (int i = 0; i < 4; i++)
    begin
      cfg = '{msel: 5'h0d, psel: 2'(i)};
      count("pll out", 3, exp[i]);
    end
    check("range x14", 4'h1, 4'(status.cco_in_range));
    cfg = '{msel: 5'h1f, psel: 2'h3};
    count("pll x32", 3, 20);
    check("range x32", 4'h0, 4'(status.cco_in_range));
    cfg = '{msel: 5'h0d, psel: 2'h1};
    main_sel = CCGEN_MAIN_PLL_OUT;
    count("main pll", 0, 35);
    main_sel = CCGEN_MAIN_IRC;
    pll_pd = 1'b1;
    nrst = 1'b0;
    @(negedge core_clk);
    nrst = 1'b1;
    check("lock reset", 4'h0, 4'(status.pll_lock));
    count("main rc again", 0, 10);
    $display("test pll done");
  endtask

  initial
  begin
    cyc = 0;
    err_count = 0;
    n_checks = 0;
    {irc_pin, sys_pin, wdo_pin, ref_sys, wdt_sel} = 5'h00;
    irc_en = 1'b1;
    pll_pd = 1'b1;
    wdo_code = 4'h0;
    cfg = '{msel: 5'h00, psel: 2'h0};
    main_sel = CCGEN_MAIN_IRC;
    out_sel = CCGEN_OUT_IRC;
    nrst = 1'b0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    t_mux();
    t_gate();
    t_pll();
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== dv/ccgen_clock_gen_properties.sv
// assertion checker for the clock generation block
`timescale 1ns/1ps
`default_nettype none
module ccgen_props
  import ccgen_pkg::*;
#(
  parameter int LOCK_CYCLES = 20
)
(
  input wire logic                       core_clk,
  input wire logic                       nrst,
  input wire logic                       irc_en,
  input wire logic                       pll_pd,
  input wire logic [3:0]                 wdo_freq_code,
  input wire ccgen_pkg::ccgen_main_sel_t main_sel,
  input wire logic                       wdt_sel_wdo,
  input wire ccgen_pkg::ccgen_out_sel_t  clkout_sel,
  input wire logic                       main_clk,
  input wire logic                       wdt_clk,
  input wire logic                       clkout,
  input wire logic                       pll_clk,
  input wire logic [3:0]                 wdo_freq_code_o,
  input wire ccgen_pkg::ccgen_status_t   status
);
  // ----------------------------------------------------------------
  // cycle counters
  // ----------------------------------------------------------------
  logic [15:0] lock_q;
  logic [15:0] lock_d;
  logic [15:0] gate_q;
  logic [15:0] gate_d;
  logic        gate_on;
  // gate only counts when every rc consumer points at the rc clock
  assign gate_on = !irc_en && main_sel == CCGEN_MAIN_IRC && !wdt_sel_wdo
                   && clkout_sel == CCGEN_OUT_IRC;
  always_comb
  begin
    lock_d = pll_pd ? 16'h0000 : lock_q + 16'(lock_q != 16'hffff);
    gate_d = !gate_on ? 16'h0000 : gate_q + 16'(gate_q != 16'hffff);
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_q <= 16'h0000;
      gate_q <= 16'h0000;
    end
    else
    begin
      lock_q <= lock_d;
      gate_q <= gate_d;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_bypass_level: assert property (
    status.pll_bypassed == pll_pd) else $error("bypass flag wrong");
  a_lock_early: assert property (
    status.pll_lock |-> lock_q >= LOCK_CYCLES - 1) else $error("early lock");
  a_lock_late: assert property (
    lock_q >= LOCK_CYCLES + 3 |-> status.pll_lock) else $error("late lock");
  a_lock_drop: assert property (
    pll_pd [*2] |-> !status.pll_lock) else $error("lock while off");
  a_code_copy: assert property (
    $past(nrst) |-> wdo_freq_code_o == $past(wdo_freq_code))
    else $error("wdo code not copied");
  a_gate_quiet: assert property (
    gate_q >= 16'h0018 |-> !main_clk && !clkout && !wdt_clk)
    else $error("gated rc still clocks");
  a_rst_idle: assert property (
    $rose(nrst) |-> !main_clk && !clkout && !pll_clk && !status.pll_lock)
    else $error("outputs active after reset");
  a_main_runt: assert property (
    $rose(main_clk) |=> main_clk) else $error("short main pulse");
  a_out_runt: assert property (
    $rose(clkout) |=> clkout) else $error("short clkout pulse");
  c_lock: cover property ($rose(status.pll_lock));
  c_pll_main: cover property (main_sel == CCGEN_MAIN_PLL_OUT && $rose(main_clk));
  c_gated: cover property (gate_q == 16'h0018);
endmodule
bind ccgen_clock_gen ccgen_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
  .core_clk(core_clk), .nrst(nrst), .irc_en(irc_en), .pll_pd(pll_pd),
  .wdo_freq_code(wdo_freq_code), .main_sel(main_sel),
  .wdt_sel_wdo(wdt_sel_wdo), .clkout_sel(clkout_sel),
  .main_clk(main_clk), .wdt_clk(wdt_clk), .clkout(clkout),
  .pll_clk(pll_clk), .wdo_freq_code_o(wdo_freq_code_o), .status(status)
);
`default_nettype wire

// ===== rtl/ccgen_clock_gen.sv
// clock source selection, pll model and clock output mux
`timescale 1ns/1ps
`default_nettype none
`include "ccgen_regs.svh"

// ----------------------------------------------------------------
// glitch-free four-way clock mux
// ----------------------------------------------------------------
module ccgen_gmux
#(
  parameter logic [1:0] RST_SEL = `CCGEN_RST_SEL
)
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] src,
  input  wire logic [1:0] sel,
  output logic            clk_o
);
  import ccgen_pkg::*;

  typedef enum {CCGEN_GM_RUN, CCGEN_GM_PARK} ccgen_gm_st_t;

  ccgen_gm_st_t st_q;
  ccgen_gm_st_t st_d;
  logic [1:0]   cur_q;
  logic [1:0]   cur_d;
  logic         out_q;
  logic         out_d;

  // switch only while the old source is low, and release only while
  // the new one is low, so no shortened high pulse ever leaves
  always_comb
  begin
    st_d  = st_q;
    cur_d = cur_q;
    out_d = out_q;
    case (st_q)
      CCGEN_GM_RUN:
      begin
        out_d = src[cur_q];
        if (sel != cur_q && !src[cur_q])          // RULE14
        begin
          st_d  = CCGEN_GM_PARK;
          out_d = 1'b0;
          cur_d = sel;
        end
      end
      CCGEN_GM_PARK:
      begin
        out_d = 1'b0;
        if (!src[cur_q])                          // RULE14
          st_d = CCGEN_GM_RUN;
      end
      default:
      begin
        st_d  = CCGEN_GM_RUN;
        out_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q  <= CCGEN_GM_RUN;
      cur_q <= RST_SEL;
      out_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cur_q <= cur_d;
      out_q <= out_d;
    end
  end

  assign clk_o = out_q;
endmodule

// Notes on behaviour
// RULE1: reset selects rc oscillator until software changes
// RULE2: 12 MHz rc clocks watchdog or pll reference
// RULE3: watchdog oscillator clocks cpu or watchdog, programmable
// RULE4: software keeps pll reference within 10-25 MHz
// RULE5: feedback multiplier is any integer 1 to 32
// RULE6: controlled oscillator stays within 156-320 MHz; the code does not hold it there, it only flags it in cco_in_range
// RULE7: software keeps pll output below 100 MHz
// RULE8: output divider 2,4,8,16 gives 50% duty
// RULE9: pll powered down and bypassed after reset
// RULE10: software configures, enables, awaits lock, then switches
// RULE11: pll locks within 100 microseconds of enable
// RULE12: clock output picks rc, system, watchdog, main
// RULE13: rc oscillator gates on and off without glitches
// RULE14: source changes produce no truncated pulses
module ccgen_clock_gen
  import ccgen_pkg::*;
#(
  parameter int LOCK_CYCLES = `CCGEN_LOCK_CYCLES,
  parameter int PER_W       = 16,
  parameter int ACC_W       = 24
)
(
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       irc_clk_pin,
  input  wire logic                       sys_osc_clk_pin,
  input  wire logic                       watchdog_oscillator_clk_pin,
  input  wire logic                       irc_en,
  input  wire logic [3:0]                 wdo_freq_code,
  input  wire logic                       pll_pd,
  input  wire logic                       pll_ref_sysosc,
  input  wire ccgen_pkg::ccgen_pll_cfg_t  pll_cfg,
  input  wire ccgen_pkg::ccgen_main_sel_t main_sel,
  input  wire logic                       wdt_sel_wdo,
  input  wire ccgen_pkg::ccgen_out_sel_t  clkout_sel,
  output logic                            main_clk,
  output logic                            wdt_clk,
  output logic                            clkout,
  output logic                            pll_clk,
  output logic [3:0]                      wdo_freq_code_o,
  output ccgen_pkg::ccgen_status_t        status
);
  import ccgen_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers, change accepted when stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  logic [2:0] lvl_d;

  assign pin_raw = {watchdog_oscillator_clk_pin, sys_osc_clk_pin,
                    irc_clk_pin};

  always_comb
  begin
    lvl_d = lvl_q;
    for (int i = 0; i < 3; i++)
      if (s2_q[i] == s3_q[i])
        lvl_d[i] = s3_q[i];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      lvl_q <= 3'h0;
    end
    else
    begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // rc oscillator gate, opens and closes only on a low phase
  // ----------------------------------------------------------------
  logic irc_gate_q;
  logic irc_gate_d;
  logic irc_lvl;
  logic sys_lvl;
  logic wdo_lvl;

  always_comb
  begin
    irc_gate_d = irc_gate_q;
    if (!lvl_q[0])
      irc_gate_d = irc_en;                        // RULE13
  end

  assign irc_lvl = lvl_q[0] & irc_gate_q;          // RULE2
  assign sys_lvl = lvl_q[1];
  assign wdo_lvl = lvl_q[2];                       // RULE3

  // ----------------------------------------------------------------
  // pll: reference period, lock timer, phase accumulator
  // ----------------------------------------------------------------
  logic             ref_lvl;
  logic             ref_prev_q;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] per_cnt_d;
  logic [PER_W-1:0] per_q;
  logic [PER_W-1:0] per_d;
  logic [15:0]      lock_cnt_q;
  logic [15:0]      lock_cnt_d;
  logic             lock_q;
  logic             lock_d;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] half_per;
  logic             osc_q;
  logic             osc_d;
  logic             pll_q;
  logic             pll_d;
  logic [5:0]       mult;
  logic [ACC_W-1:0] cco_lo;
  logic [ACC_W-1:0] cco_hi;
  logic [ACC_W-1:0] cco_x;
  logic             range_q;
  logic             range_d;

  localparam logic [15:0] LOCK_N = 16'(LOCK_CYCLES);

  assign ref_lvl  = pll_ref_sysosc ? sys_lvl : irc_lvl;
  assign mult     = 6'(pll_cfg.msel) + 6'h01;             // RULE5
  // output half period is ref period * P / M, P = 1,2,4,8
  assign half_per = ACC_W'(per_q) << pll_cfg.psel;        // RULE8
  assign acc_sum  = acc_q + ACC_W'(mult);
  assign cco_lo   = ACC_W'(per_q) * ACC_W'(`CCGEN_CCO_MIN_MHZ);
  assign cco_hi   = ACC_W'(per_q) * ACC_W'(`CCGEN_CCO_MAX_MHZ);
  assign cco_x    = ACC_W'(mult) * ACC_W'(`CCGEN_CORE_CLK_MHZ);

  always_comb
  begin
    per_cnt_d  = per_cnt_q;
    per_d      = per_q;
    lock_cnt_d = lock_cnt_q;
    lock_d     = lock_q;
    acc_d      = acc_q;
    osc_d      = osc_q;
    if (ref_lvl && !ref_prev_q)
    begin
      per_d     = per_cnt_q;
      per_cnt_d = {{(PER_W-1){1'b0}}, 1'b1};
    end
    else if (per_cnt_q != {PER_W{1'b1}})
      per_cnt_d = per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
    if (pll_pd)                                   // RULE9
    begin
      lock_cnt_d = 16'h0000;
      lock_d     = 1'b0;
      acc_d      = {ACC_W{1'b0}};
      osc_d      = 1'b0;
    end
    else
    begin
      if (lock_cnt_q >= LOCK_N - 16'h0001)         // RULE11
        lock_d = 1'b1;
      else
        lock_cnt_d = lock_cnt_q + 16'h0001;
      if (half_per == {ACC_W{1'b0}})
        acc_d = {ACC_W{1'b0}};
      else if (acc_sum >= half_per)
      begin
        acc_d = acc_sum - half_per;
        osc_d = ~osc_q;                           // RULE8
      end
      else
        acc_d = acc_sum;
    end
    // bypassed while powered down: reference passes straight on
    pll_d   = pll_pd ? ref_lvl : osc_q;           // RULE9
    range_d = (cco_x >= cco_lo) && (cco_x <= cco_hi); // RULE6
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irc_gate_q <= 1'b1;
      ref_prev_q <= 1'b0;
      per_cnt_q  <= {PER_W{1'b0}};
      per_q      <= {PER_W{1'b0}};
      lock_cnt_q <= 16'h0000;
      lock_q     <= 1'b0;
      acc_q      <= {ACC_W{1'b0}};
      osc_q      <= 1'b0;
      pll_q      <= 1'b0;
      range_q    <= 1'b0;
      wdo_freq_code_o <= `CCGEN_RST_WDO_CODE;
    end
    else
    begin
      irc_gate_q <= irc_gate_d;
      ref_prev_q <= ref_lvl;
      per_cnt_q  <= per_cnt_d;
      per_q      <= per_d;
      lock_cnt_q <= lock_cnt_d;
      lock_q     <= lock_d;
      acc_q      <= acc_d;
      osc_q      <= osc_d;
      pll_q      <= pll_d;
      range_q    <= range_d;
      wdo_freq_code_o <= wdo_freq_code;           // RULE3
    end
  end

  // ----------------------------------------------------------------
  // clock muxes
  // ----------------------------------------------------------------
  logic main_lvl;

  ccgen_gmux #(.RST_SEL(`CCGEN_RST_SEL)) u_main_mux   // RULE1
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .src      ({pll_q, wdo_lvl, ref_lvl, irc_lvl}),
    .sel      (main_sel),
    .clk_o    (main_lvl)
  );

  ccgen_gmux #(.RST_SEL(`CCGEN_RST_SEL)) u_wdt_mux
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .src      ({wdo_lvl, wdo_lvl, wdo_lvl, irc_lvl}),
    .sel      ({1'b0, wdt_sel_wdo}),
    .clk_o    (wdt_clk)
  );

  ccgen_gmux #(.RST_SEL(`CCGEN_RST_SEL)) u_out_mux   // RULE12
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .src      ({main_lvl, wdo_lvl, sys_lvl, irc_lvl}),
    .sel      (clkout_sel),
    .clk_o    (clkout)
  );

  assign main_clk            = main_lvl;
  assign pll_clk             = pll_q;
  assign status.pll_lock     = lock_q;
  assign status.pll_bypassed = pll_pd;
  assign status.cco_in_range = range_q;
endmodule
`default_nettype wire

// ===== rtl/ccgen_pkg.sv
// types for the clock generation and pll block
`default_nettype none
package ccgen_pkg;

  // main clock sources, glitch-free mux index
  typedef enum logic [1:0]
  {
    CCGEN_MAIN_IRC,
    CCGEN_MAIN_PLL_IN,
    CCGEN_MAIN_WDO,
    CCGEN_MAIN_PLL_OUT
  } ccgen_main_sel_t;

  // clock output sources
  typedef enum logic [1:0]
  {
    CCGEN_OUT_IRC,
    CCGEN_OUT_SYSOSC,
    CCGEN_OUT_WDO,
    CCGEN_OUT_MAIN
  } ccgen_out_sel_t;

  // msel holds multiplier minus one, psel picks divide by 2,4,8,16
  typedef struct packed
  {
    logic [4:0] msel;
    logic [1:0] psel;
  } ccgen_pll_cfg_t;

  typedef struct packed
  {
    logic pll_lock;
    logic pll_bypassed;
    logic cco_in_range;
  } ccgen_status_t;

endpackage
`default_nettype wire

// ===== rtl/ccgen_regs.svh
// constants for the clock generation and pll block
`ifndef CCGEN_REGS_SVH
`define CCGEN_REGS_SVH

// ----------------------------------------------------------------
// core clock and timing
// ----------------------------------------------------------------
`define CCGEN_CORE_CLK_MHZ    200
`define CCGEN_LOCK_TIME_US    100
`define CCGEN_LOCK_CYCLES     (`CCGEN_LOCK_TIME_US * `CCGEN_CORE_CLK_MHZ)

// ----------------------------------------------------------------
// oscillator and pll figures, in khz, mhz or hz10 as named
// ----------------------------------------------------------------
`define CCGEN_IRC_NOM_MHZ     12
`define CCGEN_WDO_MIN_HZ10    94
`define CCGEN_WDO_MAX_KHZ     2300
`define CCGEN_REF_MIN_MHZ     10
`define CCGEN_REF_MAX_MHZ     25
`define CCGEN_CCO_MIN_MHZ     156
`define CCGEN_CCO_MAX_MHZ     320
`define CCGEN_OUT_MAX_MHZ     100
`define CCGEN_MULT_MIN        1
`define CCGEN_MULT_MAX        32

// ----------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------
`define CCGEN_MSEL_W          5
`define CCGEN_PSEL_W          2
`define CCGEN_RST_SEL         2'h0
`define CCGEN_RST_WDO_CODE    4'h0

`endif
